// file: logic/ssf_pkg.sv
`default_nettype none
package ssf_pkg;
   // register offsets
   localparam logic [7:0] ADDR_STATUS_ONE   = 8'h00;
   localparam logic [7:0] ADDR_STATUS_TWO   = 8'h01;
   localparam logic [7:0] ADDR_FIFO_DATA    = 8'h07;
   localparam logic [7:0] ADDR_ALMOST_FULL  = 8'h08;
   localparam logic [7:0] ADDR_FIFO_CONFIG  = 8'h09;
   localparam logic [7:0] ADDR_SHUTDOWN     = 8'h11;
   localparam logic [7:0] ADDR_SLOT_SELECT  = 8'h50;
   localparam logic [7:0] ADDR_HYSTERESIS   = 8'h51;
   localparam logic [7:0] ADDR_TH1_UPPER    = 8'h52;
   localparam logic [7:0] ADDR_TH1_LOWER    = 8'h53;
   localparam logic [7:0] ADDR_TH2_UPPER    = 8'h54;
   localparam logic [7:0] ADDR_TH2_LOWER    = 8'h55;
   localparam logic [7:0] ADDR_INT_EN_ONE   = 8'h58;
   localparam logic [7:0] ADDR_INT_EN_TWO   = 8'h59;
   localparam logic [7:0] ADDR_REVISION     = 8'hFE;
   localparam logic [7:0] ADDR_IDENTIFIER   = 8'hFF;

   // field positions
   localparam int BIT_CLEAR_ON_READ = 3;
   localparam int BIT_SHUTDOWN      = 1;
   localparam int SLOT_ONE_LSB      = 0;
   localparam int SLOT_TWO_LSB      = 4;

   // status one bit positions, plus the status two invalid-config bit
   localparam int ST_ALMOST_FULL = 7;
   localparam int ST_FRAME       = 6;
   localparam int ST_NEW_DATA    = 5;
   localparam int ST_AMBIENT     = 4;
   localparam int ST_EXPOSURE    = 3;
   localparam int ST_THRESH_TWO  = 2;
   localparam int ST_THRESH_ONE  = 1;
   localparam int ST_UNDERVOLT   = 0;
   localparam int ST_INVALID_CFG = 7;

   // reset values
   localparam logic [7:0] STATUS_ONE_RESET = 8'h01;
   localparam logic [7:0] REG_RESET        = 8'h00;
   localparam logic [7:0] FIFO_DATA_MASK   = 8'hE0;  // flags a data read also clears

   // exposure range limits on the signed 20-bit result
   localparam int RESULT_W   = 20;
   localparam int EXP_MARGIN = 16384;
   localparam logic signed [RESULT_W:0] EXP_HIGH = 21'sd524287 - 21'sd16384;
   localparam logic signed [RESULT_W:0] EXP_LOW  = -21'sd131072 - 21'sd16384;

   localparam int NUM_SLOTS = 6;

   // one converted sample from the sequencer
   typedef struct packed {
      logic                      valid;
      logic [2:0]                slot;
      logic signed [RESULT_W-1:0] value;
   } ssf_result_s;

   // host register access strobe
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ssf_access_s;
endpackage : ssf_pkg
`default_nettype wire

// file: logic/ssf_threshold.sv
`default_nettype none
// one window comparator on the top byte of the selected slot's result
module ssf_threshold (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire ssf_pkg::ssf_result_s result,
   input  wire logic [2:0]          slot_sel,
   input  wire logic [7:0]          high_level,
   input  wire logic [7:0]          low_level,
   output logic                     hit
);
   logic [7:0] top_byte;

   // upper byte of the unsigned view; hysteresis qualification not modelled
   assign top_byte = result.value[ssf_pkg::RESULT_W-1 -: 8];

   // one-cycle pulse when the chosen slot lands outside the window
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hit <= 1'b0;
      end else begin
         hit <= result.valid && (result.slot == slot_sel) &&
                ((top_byte > high_level) || (top_byte < low_level));
      end
   end
endmodule : ssf_threshold
`default_nettype wire

// file: logic/ssf_exposure.sv
`default_nettype none
// flags a result beyond the usable exposure range
module ssf_exposure (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire ssf_pkg::ssf_result_s result,
   input  wire logic [5:0]          slot_enable,
   output logic                     out_of_range
);
   logic signed [ssf_pkg::RESULT_W:0] wide;
   logic                              slot_on;

   assign wide    = {result.value[ssf_pkg::RESULT_W-1], result.value};
   assign slot_on = (result.slot < 3'd6) ? slot_enable[result.slot] : 1'b0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_of_range <= 1'b0;
      end else begin
         out_of_range <= result.valid && slot_on &&
                         ((wide > ssf_pkg::EXP_HIGH) || (wide < ssf_pkg::EXP_LOW));
      end
   end
endmodule : ssf_exposure
`default_nettype wire

// file: logic/ssf_status_flags.sv
// Summary of operation
// - almost-full sets when stored FIFO item count reaches a nonzero programmed level.
// - reading status one clears all of its flags.
// - with clear-on-data-read set, FIFO data reads clear almost-full, frame, new data.
// - frame flag sets at frame end once at least one sample of that frame is written.
// - new-data flag sets whenever a sample enters the FIFO.
// - ambient flag sets when ambient cancellation hits its limit.
// - exposure flag sets when an enabled result is beyond the range limits.
// - threshold flag sets when the selected result is outside its byte window.
// - each comparator picks its slot from its own 3-bit select field.
// - undervoltage flag sets on lockout, clears on status read or shutdown, unmasked.
// - invalid-configuration flag sets on too-short frame, clears on status two read.
// - four LED compliance flags set on low driver voltage, clear on status two read.
`default_nettype none
module ssf_status_flags #(
   parameter logic [7:0] REVISION_CODE   = 8'h01,  // arbitrary value
   parameter logic [7:0] IDENTIFIER_CODE = 8'h5A   // arbitrary value
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // host register port
   input  wire ssf_pkg::ssf_access_s host_access,
   output logic [7:0]               host_rdata,
   // fifo and sequencer events
   input  wire logic [8:0]          fifo_count,
   input  wire logic                fifo_push,
   input  wire logic                frame_end,
   input  wire ssf_pkg::ssf_result_s adc_result,
   input  wire logic [5:0]          slot_enable,
   input  wire logic                ambient_overflow,
   input  wire logic                undervoltage_lockout,
   input  wire logic                frame_too_short,
   input  wire logic [3:0]          led_low_voltage,
   // status outputs
   output logic                     interrupt_out_n,
   output logic                     clear_on_data_read,
   output logic                     shutdown_bit
);
   logic [7:0] status_one_ff;
   logic [7:0] status_two_ff;
   logic [7:0] almost_full_level_ff;
   logic [7:0] slot_select_ff;
   logic [7:0] hysteresis_ff;
   logic [7:0] th1_upper_ff;
   logic [7:0] th1_lower_ff;
   logic [7:0] th2_upper_ff;
   logic [7:0] th2_lower_ff;
   logic [7:0] int_en_one_ff;
   logic [7:0] int_en_two_ff;
   logic       clear_on_data_read_ff;
   logic       shutdown_ff;
   logic       frame_pending_ff;
   logic       exposure_hit;
   logic       th1_hit;
   logic       th2_hit;
   logic       almost_full_prev_ff;
   logic [7:0] nxt_status_one;
   logic [7:0] nxt_status_two;
   logic [7:0] set_one;
   logic [7:0] clr_one;
   logic [7:0] set_two;
   logic [7:0] rdata_mux;
   logic       reached;
   logic       rd_one;
   logic       rd_two;
   logic       rd_data;

   // write decode used by every config register
   function automatic logic wr_hit(input ssf_pkg::ssf_access_s acc, input logic [7:0] addr);
      wr_hit = acc.wr && (acc.addr == addr);
   endfunction : wr_hit

   function automatic logic rd_hit(input ssf_pkg::ssf_access_s acc, input logic [7:0] addr);
      rd_hit = acc.rd && (acc.addr == addr);
   endfunction : rd_hit

   assign rd_one  = rd_hit(host_access, ssf_pkg::ADDR_STATUS_ONE);
   assign rd_two  = rd_hit(host_access, ssf_pkg::ADDR_STATUS_TWO);
   assign rd_data = rd_hit(host_access, ssf_pkg::ADDR_FIFO_DATA);

   // comparators, one per threshold channel
   ssf_threshold u_th_one (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .result     (adc_result),
      .slot_sel   (slot_select_ff[ssf_pkg::SLOT_ONE_LSB +: 3]),
      .high_level (th1_upper_ff),
      .low_level  (th1_lower_ff),
      .hit        (th1_hit)
   );

   ssf_threshold u_th_two (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .result     (adc_result),
      .slot_sel   (slot_select_ff[ssf_pkg::SLOT_TWO_LSB +: 3]),
      .high_level (th2_upper_ff),
      .low_level  (th2_lower_ff),
      .hit        (th2_hit)
   );

   ssf_exposure u_exposure (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .result       (adc_result),
      .slot_enable  (slot_enable),
      .out_of_range (exposure_hit)
   );

   // level crossing detect so a static full FIFO does not re-set after a clear
   assign reached = (fifo_count >= {1'b0, almost_full_level_ff}) &&
                    (almost_full_level_ff != ssf_pkg::REG_RESET);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         almost_full_prev_ff <= 1'b0;
      end else begin
         almost_full_prev_ff <= reached;
      end
   end

   // frame is complete at frame_end once at least one push has come since the previous frame_end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_pending_ff <= 1'b0;
      end else if (frame_end) begin
         frame_pending_ff <= 1'b0;
      end else if (fifo_push) begin
         frame_pending_ff <= 1'b1;
      end
   end

   // event sets and read clears for status one
   always_comb begin
      set_one = 8'h00;
      set_one[ssf_pkg::ST_ALMOST_FULL] = reached && !almost_full_prev_ff;
      set_one[ssf_pkg::ST_FRAME]       = frame_end && (frame_pending_ff || fifo_push);
      set_one[ssf_pkg::ST_NEW_DATA]    = fifo_push;
      set_one[ssf_pkg::ST_AMBIENT]     = ambient_overflow;
      set_one[ssf_pkg::ST_EXPOSURE]    = exposure_hit;
      set_one[ssf_pkg::ST_THRESH_TWO]  = th2_hit;
      set_one[ssf_pkg::ST_THRESH_ONE]  = th1_hit;
      set_one[ssf_pkg::ST_UNDERVOLT]   = undervoltage_lockout;
      clr_one = 8'h00;
      if (rd_one) begin
         clr_one = 8'hFF;
      end
      if (rd_data && clear_on_data_read_ff) begin
         clr_one = clr_one | ssf_pkg::FIFO_DATA_MASK;
      end
      if (wr_hit(host_access, ssf_pkg::ADDR_SHUTDOWN) &&
          host_access.wdata[ssf_pkg::BIT_SHUTDOWN]) begin
         clr_one[ssf_pkg::ST_UNDERVOLT] = 1'b1;
      end
      // a set in the clearing cycle survives
      nxt_status_one = (status_one_ff & ~clr_one) | set_one;
   end

   // status two: invalid config and LED compliance
   always_comb begin
      set_two = {frame_too_short, 3'b000, led_low_voltage};
      nxt_status_two = (rd_two ? 8'h00 : status_two_ff) | set_two;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_one_ff <= ssf_pkg::STATUS_ONE_RESET;
         status_two_ff <= ssf_pkg::REG_RESET;
      end else begin
         status_one_ff <= nxt_status_one;
         status_two_ff <= nxt_status_two;
      end
   end

   // host-written configuration; enables clear at reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         almost_full_level_ff  <= ssf_pkg::REG_RESET;
         slot_select_ff        <= ssf_pkg::REG_RESET;
         hysteresis_ff         <= ssf_pkg::REG_RESET;
         th1_upper_ff          <= ssf_pkg::REG_RESET;
         th1_lower_ff          <= ssf_pkg::REG_RESET;
         th2_upper_ff          <= ssf_pkg::REG_RESET;
         th2_lower_ff          <= ssf_pkg::REG_RESET;
         int_en_one_ff         <= ssf_pkg::REG_RESET;
         int_en_two_ff         <= ssf_pkg::REG_RESET;
         clear_on_data_read_ff <= 1'b0;
         shutdown_ff           <= 1'b0;
      end else begin
         if (wr_hit(host_access, ssf_pkg::ADDR_ALMOST_FULL)) begin
            almost_full_level_ff <= host_access.wdata;
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_SLOT_SELECT)) begin
            slot_select_ff <= host_access.wdata & 8'h77;  // bits 7 and 3 reserved
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_HYSTERESIS)) begin
            hysteresis_ff <= host_access.wdata & 8'hDF;
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_TH1_UPPER)) begin
            th1_upper_ff <= host_access.wdata;
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_TH1_LOWER)) begin
            th1_lower_ff <= host_access.wdata;
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_TH2_UPPER)) begin
            th2_upper_ff <= host_access.wdata;
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_TH2_LOWER)) begin
            th2_lower_ff <= host_access.wdata;
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_INT_EN_ONE)) begin
            int_en_one_ff <= host_access.wdata & 8'hFE;   // bit 0 has no enable
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_INT_EN_TWO)) begin
            int_en_two_ff <= host_access.wdata & 8'h8F;
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_FIFO_CONFIG)) begin
            clear_on_data_read_ff <= host_access.wdata[ssf_pkg::BIT_CLEAR_ON_READ];
         end
         if (wr_hit(host_access, ssf_pkg::ADDR_SHUTDOWN)) begin
            shutdown_ff <= host_access.wdata[ssf_pkg::BIT_SHUTDOWN];
         end
      end
   end

   // read data mux; unmapped addresses return zero
   always_comb begin
      case (host_access.addr)
         ssf_pkg::ADDR_STATUS_ONE:  rdata_mux = status_one_ff;
         ssf_pkg::ADDR_STATUS_TWO:  rdata_mux = status_two_ff;
         ssf_pkg::ADDR_ALMOST_FULL: rdata_mux = almost_full_level_ff;
         ssf_pkg::ADDR_FIFO_CONFIG: rdata_mux = {4'h0, clear_on_data_read_ff, 3'h0};
         ssf_pkg::ADDR_SHUTDOWN:    rdata_mux = {6'h00, shutdown_ff, 1'b0};
         ssf_pkg::ADDR_SLOT_SELECT: rdata_mux = slot_select_ff;
         ssf_pkg::ADDR_HYSTERESIS:  rdata_mux = hysteresis_ff;
         ssf_pkg::ADDR_TH1_UPPER:   rdata_mux = th1_upper_ff;
         ssf_pkg::ADDR_TH1_LOWER:   rdata_mux = th1_lower_ff;
         ssf_pkg::ADDR_TH2_UPPER:   rdata_mux = th2_upper_ff;
         ssf_pkg::ADDR_TH2_LOWER:   rdata_mux = th2_lower_ff;
         ssf_pkg::ADDR_INT_EN_ONE:  rdata_mux = int_en_one_ff;
         ssf_pkg::ADDR_INT_EN_TWO:  rdata_mux = int_en_two_ff;
         ssf_pkg::ADDR_REVISION:    rdata_mux = REVISION_CODE;
         ssf_pkg::ADDR_IDENTIFIER:  rdata_mux = IDENTIFIER_CODE;
         default:                   rdata_mux = 8'h00;
      endcase
   end

   // read data registered so the value seen is the pre-clear status
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_rdata <= 8'h00;
      end else if (host_access.rd) begin
         host_rdata <= rdata_mux;
      end
   end

   // interrupt registered from the next flag values; undervoltage ignores enables
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= !(|(nxt_status_one & int_en_one_ff) ||
                              nxt_status_one[ssf_pkg::ST_UNDERVOLT] ||
                              |(nxt_status_two & int_en_two_ff));
      end
   end

   assign clear_on_data_read = clear_on_data_read_ff;
   assign shutdown_bit       = shutdown_ff;
endmodule : ssf_status_flags
`default_nettype wire

// file: tb/ssf_host.sv
`default_nettype none
// host side of the register port: one-cycle strobe, answer a cycle later
module ssf_host (
   input  wire logic                clk,
   input  wire logic [7:0]          host_rdata,
   output var ssf_pkg::ssf_access_s host_access
);
   timeunit 1ns;
   timeprecision 1ps;
   initial host_access = '0;
   // strobe launched on an edge, dropped at the edge that takes it
   task automatic access(input logic r, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk);
      host_access <= '{r, !r, a, d};
      @(posedge clk);
      host_access <= '0;
      #1 q = host_rdata;  // read data lands on the taking edge
   endtask : access
endmodule : ssf_host
`default_nettype wire

// file: tb/ssf_status_flags_asserts.sv
`default_nettype none
module ssf_status_flags_asserts (
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire ssf_pkg::ssf_access_s host_access,
   input wire logic [7:0]           host_rdata,
   input wire logic                 fifo_push,
   input wire logic                 frame_end,
   input wire logic                 ambient_overflow,
   input wire logic                 undervoltage_lockout,
   input wire logic                 frame_too_short,
   input wire logic [3:0]           led_low_voltage,
   input wire logic                 interrupt_out_n,
   input wire logic                 clear_on_data_read
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic rd0, rd1, rd7;
   // decoded reads of status one, status two and fifo data
   assign rd0 = host_access.rd && host_access.addr == 8'h00;
   assign rd1 = host_access.rd && host_access.addr == 8'h01;
   assign rd7 = host_access.rd && host_access.addr == 8'h07;
   // event, two idle bus cycles, then a read: flag must be visible by then
   // idle also excludes writes, since a shutdown write clears undervoltage
   sequence s_seen(ev, rdx);
      ev ##1 (!host_access.rd && !host_access.wr) [*2] ##1 rdx;
   endsequence
   AST_UV_INT: assert property (undervoltage_lockout |=> !interrupt_out_n)
      else $error("undervoltage did not pull the interrupt");
   AST_RESET_UV: assert property ($fell(sys_rst) |=> !interrupt_out_n)
      else $error("interrupt not low after reset release");
   AST_AMB_SEEN: assert property (s_seen(ambient_overflow, rd0) |=> host_rdata[4])
      else $error("ambient flag missing");
   AST_NEW_SEEN: assert property (s_seen(fifo_push, rd0) |=> host_rdata[5])
      else $error("new data flag missing");
   AST_FRAME_SEEN: assert property (fifo_push ##1 s_seen(frame_end, rd0) |=> host_rdata[6])
      else $error("frame flag missing");
   AST_UV_SEEN: assert property (s_seen(undervoltage_lockout, rd0) |=> host_rdata[0])
      else $error("undervoltage flag missing");
   AST_CFG_SEEN: assert property (s_seen(frame_too_short, rd1) |=> host_rdata[7])
      else $error("invalid config flag missing");
   AST_LED_SEEN: assert property (s_seen(led_low_voltage != 4'h0, rd1) |=>
      (host_rdata[3:0] & $past(led_low_voltage, 4)) == $past(led_low_voltage, 4))
      else $error("compliance flag missing");
   AST_READ_CLEARS: assert property (!ambient_overflow ##1 (rd0 && !ambient_overflow) ##1
      !ambient_overflow ##1 (rd0 && !ambient_overflow) |=> !host_rdata[4])
      else $error("status read did not clear");
   AST_DATA_CLEARS: assert property (!fifo_push ##1 (clear_on_data_read && rd7 && !fifo_push)
      ##1 !fifo_push ##1 (rd0 && !fifo_push) |=> !host_rdata[5])
      else $error("data read did not clear");
endmodule : ssf_status_flags_asserts
bind ssf_status_flags ssf_status_flags_asserts i_asserts (.clk(clk), .sys_rst(sys_rst),
   .host_access(host_access), .host_rdata(host_rdata), .fifo_push(fifo_push),
   .frame_end(frame_end), .ambient_overflow(ambient_overflow),
   .undervoltage_lockout(undervoltage_lockout), .frame_too_short(frame_too_short),
   .led_low_voltage(led_low_voltage), .interrupt_out_n(interrupt_out_n),
   .clear_on_data_read(clear_on_data_read));
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk = 0, sys_rst = 1, fifo_push, frame_end, ambient_overflow;
   logic                 undervoltage_lockout, frame_too_short, interrupt_out_n;
   logic                 clear_on_data_read, shutdown_bit;
   logic [7:0]           host_rdata, v;
   logic [8:0]           fifo_count;
   logic [5:0]           slot_enable;
   logic [3:0]           led_low_voltage;
   logic [2:0]           s1, s2, sl;
   logic [15:0]          seed = 16'hCD61;
   logic signed [19:0]   ev [5];
   ssf_pkg::ssf_access_s host_access;
   ssf_pkg::ssf_result_s adc_result;
   int                   failures = 0, comparisons = 0, cycles = 0;
   logic [7:0]           ra [8] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h58, 8'h59};
   logic [7:0]           rm [8] = '{8'h77, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'h8F};
   always #2.5 clk = ~clk;
   ssf_status_flags i_ssf_status_flags (.clk(clk), .sys_rst(sys_rst),
      .host_access(host_access), .host_rdata(host_rdata), .fifo_count(fifo_count),
      .fifo_push(fifo_push), .frame_end(frame_end), .adc_result(adc_result),
      .slot_enable(slot_enable), .ambient_overflow(ambient_overflow),
      .undervoltage_lockout(undervoltage_lockout), .frame_too_short(frame_too_short),
      .led_low_voltage(led_low_voltage), .interrupt_out_n(interrupt_out_n),
      .clear_on_data_read(clear_on_data_read), .shutdown_bit(shutdown_bit));
   ssf_host i_ssf_host (.clk(clk), .host_rdata(host_rdata), .host_access(host_access));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // comparator sees the top byte as unsigned
   function automatic logic hit(input logic [7:0] t);
      return t > 8'hA0 || t < 8'h40;
   endfunction : hit
   function automatic logic exp_out(input logic signed [19:0] x);
      return x > ssf_pkg::EXP_HIGH || x < ssf_pkg::EXP_LOW;
   endfunction : exp_out
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      i_ssf_host.access(1'b1, a, 8'h00, v);
      chk(n, v, e);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_ssf_host.access(1'b0, a, d, v);
   endtask : wr
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic res(input logic [2:0] s, input logic signed [19:0] x);
      @(posedge clk) adc_result <= '{1'b1, s, x};
      @(posedge clk) adc_result <= '0;
   endtask : res
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // hang guard, well above the run's length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   initial begin
      {fifo_count, fifo_push, frame_end, slot_enable, ambient_overflow} = '0;
      {undervoltage_lockout, frame_too_short, led_low_voltage} = '0;
      adc_result = '0;
      tick(5);
      sys_rst <= 0;
      tick(2);
      #1 chk("int", {7'h0, interrupt_out_n}, 8'h00);
      rd(8'h00, 8'h01, "status one");
      rd(8'h00, 8'h00, "status one");
      rd(8'h58, 8'h00, "enable one");
      rd(8'h59, 8'h00, "enable two");
      rd(8'h02, 8'h00, "unmapped");
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(ra[i], seed[7:0]);
         rd(ra[i], seed[7:0] & rm[i], "rw reg");
         wr(ra[i], 8'h00);
      end
      #1 chk("int", {7'h0, interrupt_out_n}, 8'h01);
      wr(8'h08, 8'd10);
      rd(8'h08, 8'h0A, "level");
      for (int k = 0; k < 2; k++) begin
         fifo_count <= 9'd9;
         tick(2);
         rd(8'h00, 8'h00, "below level");
         wr(8'h09, {4'h0, k[0], 3'h0});
         chk("clear opt", {7'h0, clear_on_data_read}, {7'h0, k[0]});
         @(posedge clk) fifo_push <= 1;
         fifo_count <= 9'd10;
         @(posedge clk) fifo_push <= 0;
         frame_end <= 1;
         @(posedge clk) frame_end <= 0;
         i_ssf_host.access(1'b1, 8'h07, 8'h00, v);
         rd(8'h00, k ? 8'h00 : 8'hE0, "data flags");
      end
      // lone push, then push and frame end, each read after two idle cycles
      @(posedge clk) fifo_push <= 1;
      @(posedge clk) fifo_push <= 0;
      tick(1);
      rd(8'h00, 8'h20, "new data");
      @(posedge clk) fifo_push <= 1;
      @(posedge clk) fifo_push <= 0;
      frame_end <= 1;
      @(posedge clk) frame_end <= 0;
      tick(1);
      rd(8'h00, 8'h60, "frame");
      wr(8'h09, 8'h00);
      for (int k = 0; k < 2; k++) begin
         wr(8'h58, k ? 8'h00 : 8'h10);
         @(posedge clk) ambient_overflow <= 1;
         @(posedge clk) ambient_overflow <= 0;
         tick(1);
         #1 chk("int", {7'h0, interrupt_out_n}, {7'h0, k[0]});
         rd(8'h00, 8'h10, "ambient");
         tick(1);
         #1 chk("int", {7'h0, interrupt_out_n}, 8'h01);
      end
      ev = '{20'(ssf_pkg::EXP_HIGH), 20'(ssf_pkg::EXP_HIGH + 1), 20'(ssf_pkg::EXP_LOW),
             20'(ssf_pkg::EXP_LOW - 1), 20'(ssf_pkg::EXP_HIGH + 1)};
      slot_enable <= 6'h04;
      for (int i = 0; i < 5; i++) begin
         res((i == 4) ? 3'd3 : 3'd2, ev[i]);
         tick(2);
         rd(8'h00, {4'h0, i != 4 && exp_out(ev[i]), 3'h0}, "exposure");
      end
      slot_enable <= 6'h00;
      wr(8'h52, 8'hA0);
      wr(8'h53, 8'h40);
      wr(8'h54, 8'hA0);
      wr(8'h55, 8'h40);
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         s1 = 3'(i % 6);
         s2 = 3'((i + 3) % 6);
         sl = seed[15] ? s1 : s2;
         v = (i < 4) ? (i[1] ? 8'h40 - 8'(i[0]) : 8'hA0 + 8'(i[0])) : seed[7:0];
         wr(8'h50, {1'b0, s2, 1'b0, s1});
         res(s1, 20'h80000);
         res(s2, 20'h80000);
         i_ssf_host.access(1'b1, 8'h00, 8'h00, v);
         v = (i < 4) ? (i[1] ? 8'h40 - 8'(i[0]) : 8'hA0 + 8'(i[0])) : seed[7:0];
         res(sl, {v, seed[11:0]});
         tick(2);
         rd(8'h00, {5'h0, sl == s2 && hit(v), sl == s1 && hit(v), 1'b0}, "threshold");
      end
      // lockout read back plainly, then cleared by a shutdown write
      @(posedge clk) undervoltage_lockout <= 1;
      @(posedge clk) undervoltage_lockout <= 0;
      tick(1);
      rd(8'h00, 8'h01, "undervoltage");
      @(posedge clk) undervoltage_lockout <= 1;
      @(posedge clk) undervoltage_lockout <= 0;
      tick(1);
      #1 chk("int", {7'h0, interrupt_out_n}, 8'h00);
      wr(8'h11, 8'h02);
      chk("shutdown", {7'h0, shutdown_bit}, 8'h01);
      rd(8'h00, 8'h00, "undervoltage");
      wr(8'h11, 8'h00);
      wr(8'h59, 8'h80);
      seed = lfsr(seed);
      @(posedge clk) frame_too_short <= 1;
      led_low_voltage <= seed[3:0] | 4'h1;
      @(posedge clk) frame_too_short <= 0;
      led_low_voltage <= 4'h0;
      tick(1);
      #1 chk("int", {7'h0, interrupt_out_n}, 8'h00);
      rd(8'h01, {4'h8, seed[3:0] | 4'h1}, "status two");
      rd(8'h01, 8'h00, "status two");
      tick(1);
      #1 chk("int", {7'h0, interrupt_out_n}, 8'h01);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
